// ### achc_defines.svh
// register offsets, field positions, reset values and counts of the coder host registers
`ifndef ACHC_DEFINES_SVH
`define ACHC_DEFINES_SVH

// ==========================================================================
// register offsets
`define ACHC_OFS_SYS      4'h0
`define ACHC_OFS_PARA     4'h1
`define ACHC_OFS_CMD      4'h2

// ==========================================================================
// system_config fields
`define ACHC_SYS_HR       0
`define ACHC_SYS_CB_LO    1
`define ACHC_SYS_CB_HI    2
`define ACHC_SYS_DS       3
`define ACHC_SYS_BS       4
`define ACHC_SYS_BX       5
`define ACHC_SYS_PI       6
`define ACHC_SYS_PB       7
`define ACHC_SYS_HR_MASK  8'h01

// ==========================================================================
// coding_params fields
`define ACHC_PARA_AT_LO   4
`define ACHC_PARA_TM      5
`define ACHC_PARA_AT_HI   7
`define ACHC_PARA_AT_HLO  6

// ==========================================================================
// command_port and status_port fields
`define ACHC_CMD_IC       0
`define ACHC_CMD_JC       1
`define ACHC_CMD_RC       2
`define ACHC_CMD_JP       3
`define ACHC_ST_JS        0
`define ACHC_ST_DS        1
`define ACHC_ST_MS        2
`define ACHC_ST_IS        3
`define ACHC_ST_SC        4
`define ACHC_ST_PS        5

// ==========================================================================
// reset values and counts
`define ACHC_RST_SYS      8'h00
`define ACHC_RST_PARA     8'h00
`define ACHC_FF_BYTE      8'hFF
`define ACHC_SC_WIDTH     16

`endif

// ### achc_pkg.sv
// types shared by the coder host register block
package achc_pkg;

   // ==========================================================================
   // code bus width encodings
   typedef enum logic [1:0] {
      ACHC_CW_8   = 2'b00,
      ACHC_CW_16  = 2'b01,
      ACHC_CW_32  = 2'b10,
      ACHC_CW_BAD = 2'b11
   } achc_code_width_t;

   // ==========================================================================
   // job sequencing states
   typedef enum logic [1:0] {
      ACHC_JOB_IDLE  = 2'b00,
      ACHC_JOB_RUN   = 2'b01,
      ACHC_JOB_PAUSE = 2'b11
   } achc_job_state_t;

endpackage : achc_pkg

// ### achc_regs.sv
// host control and status registers of the binary-image arithmetic coder
`timescale 1ns/1ps
`include "achc_defines.svh"

module achc_regs
   import achc_pkg::*;
#(
   parameter int SC_WIDTH = `ACHC_SC_WIDTH
) (
   input  wire logic        clock_i,
   input  wire logic        rstn_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   input  wire logic        ctx_init_done_i,
   input  wire logic        lines_done_i,
   input  wire logic        code_xfer_request_pin_i,
   input  wire logic        irq_pin_i,
   input  wire logic        marker_detect_i,
   input  wire logic        code_byte_valid_i,
   input  wire logic [7:0]  code_byte_i,
   input  wire logic        code_end_i,
   input  wire logic [31:0] image_pix_i,
   output logic             chip_reset_o,
   output logic             proc_run_o,
   output logic             early_stop_o,
   output logic             ctx_init_o,
   output logic             ctx_loadstore_o,
   output logic [1:0]       code_bus_width_o,
   output logic             code_bit_order_o,
   output logic             code_byte_order_o,
   output logic             image_if_select_o,
   output logic             image_bus_width_o,
   output logic             image_bit_order_o,
   output logic             template_select_o,
   output logic [6:0]       adaptive_pixel_pos_o,
   output logic [31:0]      code_word_o,
   output logic             code_word_valid_o,
   output logic [31:0]      image_bus_pins_o
);

   // ==========================================================================
   // reset release
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ==========================================================================
   // bus decode
   logic [7:0]      system_config;
   logic [7:0]      coding_params;
   achc_job_state_t job_state;
   achc_job_state_t next_job_state;
   logic            ctx_busy;
   logic            loadstore;
   logic            pause_mode_select;
   logic            job_done_flag;
   logic            marker_seen_flag;
   logic            ff_run_overflow;
   logic [SC_WIDTH-1:0] ff_count;

   wire sys_wr  = wr_i & (addr_i == `ACHC_OFS_SYS);
   wire para_wr = wr_i & (addr_i == `ACHC_OFS_PARA);
   wire cmd_wr  = wr_i & (addr_i == `ACHC_OFS_CMD);
   wire srst    = system_config[`ACHC_SYS_HR];

   wire run_set = cmd_wr & wdata_i[`ACHC_CMD_JC];
   wire run_clr = cmd_wr & ~wdata_i[`ACHC_CMD_JC];
   wire ic_set  = cmd_wr & wdata_i[`ACHC_CMD_IC];

   // status read instead of last command
   wire [7:0] status_port = {2'b00,
                             pause_mode_select,
                             ff_run_overflow,
                             irq_pin_i,
                             marker_seen_flag,
                             code_xfer_request_pin_i,
                             job_done_flag};

   wire [7:0] read_mux = (addr_i == `ACHC_OFS_SYS)  ? system_config :
                         (addr_i == `ACHC_OFS_PARA) ? coding_params :
                         (addr_i == `ACHC_OFS_CMD)  ? status_port   :
                                                      8'h00;

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rd_i ? read_mux : 8'h00;
      end
   end

   // ==========================================================================
   // system and parameter registers
   wire [7:0] sys_wr_val = sys_wr ? wdata_i : system_config;
   // other fields held at reset value while the reset bit is one
   wire [7:0] next_system_config = sys_wr_val[`ACHC_SYS_HR] ?
                                   (sys_wr_val & `ACHC_SYS_HR_MASK) : sys_wr_val;

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         system_config <= `ACHC_RST_SYS;
      end else begin
         system_config <= next_system_config;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         coding_params <= `ACHC_RST_PARA;
      end else if (srst) begin
         coding_params <= `ACHC_RST_PARA;
      end else if (para_wr) begin
         coding_params <= wdata_i;
      end
   end

   // fields straight from the register flops
   assign chip_reset_o         = srst;
   assign code_bus_width_o     = system_config[`ACHC_SYS_CB_HI:`ACHC_SYS_CB_LO];
   assign code_bit_order_o     = system_config[`ACHC_SYS_BS];
   assign code_byte_order_o    = system_config[`ACHC_SYS_BX];
   assign image_if_select_o    = system_config[`ACHC_SYS_PI];
   assign image_bus_width_o    = system_config[`ACHC_SYS_PB];
   assign image_bit_order_o    = system_config[`ACHC_SYS_DS];
   assign template_select_o    = coding_params[`ACHC_PARA_TM];
   assign adaptive_pixel_pos_o = {coding_params[`ACHC_PARA_AT_HI:`ACHC_PARA_AT_HLO],
                                  coding_params[`ACHC_PARA_AT_LO:0]};
   assign ctx_init_o           = ctx_busy;
   assign ctx_loadstore_o      = loadstore;

   // ==========================================================================
   // job sequencing
   always_comb begin
      next_job_state = job_state;
      unique case (job_state)
         ACHC_JOB_IDLE: begin
            if (run_set) begin
               next_job_state = ACHC_JOB_RUN;
            end
         end
         ACHC_JOB_RUN: begin
            if (run_clr) begin
               next_job_state = ACHC_JOB_IDLE;
            end else if (lines_done_i) begin
               next_job_state = pause_mode_select ? ACHC_JOB_PAUSE
                                                  : ACHC_JOB_IDLE;
            end
         end
         ACHC_JOB_PAUSE: begin
            if (run_clr) begin
               next_job_state = ACHC_JOB_IDLE;
            end else if (run_set) begin
               next_job_state = ACHC_JOB_RUN;
            end
         end
         default: begin
            next_job_state = ACHC_JOB_IDLE;
         end
      endcase
   end

   wire term_end  = (job_state == ACHC_JOB_RUN) & lines_done_i & ~run_clr & ~pause_mode_select;
   wire init_end  = ctx_busy & ctx_init_done_i;
   wire stop_now  = (job_state == ACHC_JOB_RUN) & run_clr;
   wire ff_byte   = code_byte_valid_i & (code_byte_i == `ACHC_FF_BYTE);
   wire ff_wrap   = ff_byte & (&ff_count);

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         job_state    <= ACHC_JOB_IDLE;
         proc_run_o   <= 1'b0;
         early_stop_o <= 1'b0;
      end else if (srst) begin
         job_state    <= ACHC_JOB_IDLE;
         proc_run_o   <= 1'b0;
         early_stop_o <= 1'b0;
      end else begin
         job_state    <= next_job_state;
         proc_run_o   <= (next_job_state == ACHC_JOB_RUN);
         early_stop_o <= stop_now;
      end
   end

   // ==========================================================================
   // command bits and sticky flags, set wins over clear
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         ctx_busy          <= 1'b0;
         loadstore         <= 1'b0;
         pause_mode_select <= 1'b0;
         job_done_flag     <= 1'b0;
         marker_seen_flag  <= 1'b0;
         ff_run_overflow   <= 1'b0;
      end else if (srst) begin
         ctx_busy          <= 1'b0;
         loadstore         <= 1'b0;
         pause_mode_select <= 1'b0;
         job_done_flag     <= 1'b0;
         marker_seen_flag  <= 1'b0;
         ff_run_overflow   <= 1'b0;
      end else begin
         ctx_busy          <= ic_set | (ctx_busy & ~ctx_init_done_i);
         loadstore         <= cmd_wr ? wdata_i[`ACHC_CMD_RC] : loadstore;
         pause_mode_select <= cmd_wr ? wdata_i[`ACHC_CMD_JP] : pause_mode_select;
         job_done_flag     <= init_end | term_end |
                              (job_done_flag & ~(run_set | ic_set));
         marker_seen_flag  <= marker_detect_i | (marker_seen_flag & ~run_set);
         ff_run_overflow   <= ff_wrap | (ff_run_overflow & ~run_set);
      end
   end

   // consecutive 0xFF counter, coding goes on after overflow
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         ff_count <= '0;
      end else if (srst) begin
         ff_count <= '0;
      end else if (code_byte_valid_i) begin
         ff_count <= ff_byte ? ff_count + 1'b1 : '0;
      end
   end

   // ==========================================================================
   // code bus packer
   logic [31:0] pack_acc;
   logic [1:0]  pack_cnt;
   logic [31:0] lane_word;

   wire [1:0] lane_last = (code_bus_width_o == ACHC_CW_32) ? 2'd3 :
                          (code_bus_width_o == ACHC_CW_16) ? 2'd1 : 2'd0;
   wire [7:0] byte_rev  = {code_byte_i[0], code_byte_i[1], code_byte_i[2], code_byte_i[3],
                           code_byte_i[4], code_byte_i[5], code_byte_i[6], code_byte_i[7]};
   // incoming bit 7 is the earliest bit
   wire [7:0] byte_in   = code_bit_order_o ? byte_rev : code_byte_i;
   wire       word_done = code_byte_valid_i & ((pack_cnt == lane_last) | code_end_i);

   logic [31:0] next_pack_acc;
   always_comb begin
      next_pack_acc = pack_acc;
      next_pack_acc[{pack_cnt, 3'b000} +: 8] = byte_in;
   end

   // earliest byte to lane 0, reversed under byte swap; unused lanes zero
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_lane
         wire [1:0] src = code_byte_order_o ? (lane_last - 2'(k)) : 2'(k);
         assign lane_word[8*k +: 8] = (2'(k) > lane_last) ? 8'h00 :
                                      next_pack_acc[{src, 3'b000} +: 8];
      end
   endgenerate

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         pack_acc          <= 32'h0000_0000;
         pack_cnt          <= 2'd0;
         code_word_o       <= 32'h0000_0000;
         code_word_valid_o <= 1'b0;
      end else if (srst) begin
         pack_acc          <= 32'h0000_0000;
         pack_cnt          <= 2'd0;
         code_word_o       <= 32'h0000_0000;
         code_word_valid_o <= 1'b0;
      end else if (word_done) begin
         // acc is cleared, so unfilled lanes of a last word carry zero bytes
         pack_acc          <= 32'h0000_0000;
         pack_cnt          <= 2'd0;
         code_word_o       <= lane_word;
         code_word_valid_o <= 1'b1;
      end else begin
         pack_acc          <= code_byte_valid_i ? next_pack_acc : pack_acc;
         pack_cnt          <= code_byte_valid_i ? pack_cnt + 2'd1 : pack_cnt;
         code_word_valid_o <= 1'b0;
      end
   end

   // ==========================================================================
   // parallel image bus ordering, image_pix_i[0] is the leftmost pixel
   logic [31:0] par_word;

   generate
      for (k = 0; k < 32; k++) begin : g_pix
         wire p32 = image_bit_order_o ? image_pix_i[k] : image_pix_i[31-k];
         if (k < 16) begin : g_low
            wire p16 = image_bit_order_o ? image_pix_i[k] : image_pix_i[15-k];
            assign par_word[k] = image_bus_width_o ? p16 : p32;
         end else begin : g_high
            assign par_word[k] = image_bus_width_o ? 1'b0 : p32;
         end
      end
   endgenerate

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         image_bus_pins_o <= 32'h0000_0000;
      end else if (srst) begin
         image_bus_pins_o <= 32'h0000_0000;
      end else begin
         image_bus_pins_o <= image_if_select_o ? par_word : 32'h0000_0000;
      end
   end

   // ==========================================================================
   // checks
   property p_soft_reset_holds;
      @(posedge clock_i) disable iff (!rst_n)
      sys_wr && wdata_i[`ACHC_SYS_HR] |=> chip_reset_o && system_config[7:1] == 7'h00
                                          ##1 !proc_run_o;
   endproperty
   a_soft_reset_holds: assert property (p_soft_reset_holds)
      else $error("soft reset bit did not hold the block in reset");

   property p_init_ends;
      @(posedge clock_i) disable iff (!rst_n)
      ctx_busy && ctx_init_done_i && !ic_set && !srst |=> !ctx_init_o && job_done_flag;
   endproperty
   a_init_ends: assert property (p_init_ends)
      else $error("context init bit did not drop with done flag");

   property p_terminate_end;
      @(posedge clock_i) disable iff (!rst_n)
      term_end && !srst |=> job_state == ACHC_JOB_IDLE && !proc_run_o && job_done_flag;
   endproperty
   a_terminate_end: assert property (p_terminate_end)
      else $error("terminate end did not clear run and set done");

   property p_pause_end;
      @(posedge clock_i) disable iff (!rst_n)
      job_state == ACHC_JOB_RUN && lines_done_i && pause_mode_select && !cmd_wr && !srst
      |=> job_state == ACHC_JOB_PAUSE && !proc_run_o && !job_done_flag;
   endproperty
   a_pause_end: assert property (p_pause_end)
      else $error("pause did not halt or set done wrongly");

   property p_status_read;
      @(posedge clock_i) disable iff (!rst_n)
      rd_i && addr_i == `ACHC_OFS_CMD |=> rdata_o[`ACHC_ST_DS] == $past(code_xfer_request_pin_i)
                                        && rdata_o[`ACHC_ST_IS] == $past(irq_pin_i);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read does not reflect the pins");

   property p_marker_sticky;
      @(posedge clock_i) disable iff (!rst_n)
      marker_detect_i && !srst |=> marker_seen_flag;
   endproperty
   a_marker_sticky: assert property (p_marker_sticky)
      else $error("marker flag lost");

   property p_early_stop;
      @(posedge clock_i) disable iff (!rst_n)
      job_state == ACHC_JOB_RUN && run_clr && !srst |=> early_stop_o ##1 !early_stop_o;
   endproperty
   a_early_stop: assert property (p_early_stop)
      else $error("early stop pulse wrong");

   property p_pad_zero;
      @(posedge clock_i) disable iff (!rst_n)
      code_byte_valid_i && code_end_i && pack_cnt == 2'd0 && lane_last == 2'd3 && !srst
      |=> code_word_valid_o && ($past(code_byte_order_o) ? code_word_o[23:0] == 24'h000000
                                                         : code_word_o[31:8] == 24'h000000);
   endproperty
   a_pad_zero: assert property (p_pad_zero)
      else $error("last code word not padded with zero bytes");

   property p_ff_overflow;
      @(posedge clock_i) disable iff (!rst_n)
      ff_wrap && !srst |=> ff_run_overflow && ff_count == '0;
   endproperty
   a_ff_overflow: assert property (p_ff_overflow)
      else $error("ff run overflow not flagged");

   property p_image_order;
      @(posedge clock_i) disable iff (!rst_n)
      image_if_select_o && !image_bus_width_o && !image_bit_order_o && !srst
      |=> image_bus_pins_o[31] == $past(image_pix_i[0]);
   endproperty
   a_image_order: assert property (p_image_order)
      else $error("leftmost pixel not on top pin");

endmodule : achc_regs

// ### achc_host_model.sv
// host microprocessor model driving the register port
`timescale 1ns/1ps
module achc_host_model (
   input  wire logic       clock_i,
   output logic      [3:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o,
   input  wire logic [7:0] rdata_i
);
   initial begin
      addr_o  = 4'h0;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end

   // ==========================================================================
   // bus cycles
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clock_i);
      wr_o    <= 1'b0;
      wdata_o <= ~d;  // no stale data once released
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clock_i);
      rd_o <= 1'b0;
      #1;
      d = rdata_i;
   endtask : rd_reg
endmodule : achc_host_model

// ### test_arith_coder_host_control_regs.sv
// self-checking bench of the coder host register block
`timescale 1ns/1ps
module test_arith_coder_host_control_regs;
   import achc_pkg::*;
   logic clock_i, rstn_i, wr_i, rd_i, init_done, lines_done, xfer_req, irq, marker;
   logic byte_vld, code_end, chip_rst, run, early, ctx_init, ctx_ls, cbo, cbx, isel, iw, ibo, tsel;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, code_byte, s, p, d;
   logic [1:0] cbw;
   logic [6:0] at;
   logic [31:0] cword, img, pix, last_word;
   logic cw_vld;
   int failures, checks_done, cycles, n_stop;

   achc_regs #(.SC_WIDTH(3)) u_achc_regs (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .ctx_init_done_i(init_done),
      .lines_done_i(lines_done), .code_xfer_request_pin_i(xfer_req), .irq_pin_i(irq),
      .marker_detect_i(marker), .code_byte_valid_i(byte_vld), .code_byte_i(code_byte),
      .code_end_i(code_end), .image_pix_i(pix), .chip_reset_o(chip_rst), .proc_run_o(run),
      .early_stop_o(early), .ctx_init_o(ctx_init), .ctx_loadstore_o(ctx_ls),
      .code_bus_width_o(cbw), .code_bit_order_o(cbo), .code_byte_order_o(cbx),
      .image_if_select_o(isel), .image_bus_width_o(iw), .image_bit_order_o(ibo),
      .template_select_o(tsel), .adaptive_pixel_pos_o(at), .code_word_o(cword),
      .code_word_valid_o(cw_vld), .image_bus_pins_o(img));
   achc_host_model u_achc_host_model (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata));

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // ==========================================================================
   // watchdog and output capture
   always @(posedge clock_i) begin
      cycles++;
      if (early === 1'b1) n_stop++;
      if (cw_vld === 1'b1) last_word <= cword;
      if (cycles == 20000) begin
         failures++;
         test_done();
      end
   end

   // ==========================================================================
   // helpers
   task automatic test_done;
      if (failures == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      u_achc_host_model.wr_reg(a, v);
      #1;
   endtask : wr
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      u_achc_host_model.rd_reg(a, d);
      chk({24'h0, d}, {24'h0, e});
   endtask : rdc
   task automatic send(input logic [7:0] b, input logic e);
      @(posedge clock_i);
      byte_vld  <= 1'b1;
      code_byte <= b;
      code_end  <= e;
   endtask : send
   task automatic pulse(input int k);
      @(posedge clock_i);
      {marker, lines_done, init_done} <= 3'b001 << k;
      @(posedge clock_i);
      {marker, lines_done, init_done} <= 3'b000;
      tick(1);
   endtask : pulse
   function automatic logic [31:0] rev(input logic [31:0] v);
      for (int i = 0; i < 32; i++) rev[i] = v[31-i];
   endfunction : rev
   function automatic logic [31:0] img_exp(input logic [7:0] c, input logic [31:0] v);
      if (!c[6]) return 32'h0;
      if (!c[7]) return c[3] ? v : rev(v);
      return c[3] ? {16'h0, v[15:0]} : rev({v[15:0], 16'h0});
   endfunction : img_exp
   function automatic logic [31:0] code_exp(input logic [23:0] b, input logic bx, input logic bs);
      logic [23:0] r;
      r = bs ? 24'(rev({8'h00, b}) >> 8) : b;
      r = bs ? {r[7:0], r[15:8], r[23:16]} : r;
      return bx ? {r[7:0], r[15:8], r[23:16], 8'h00} : {8'h00, r};
   endfunction : code_exp

   // ==========================================================================
   // main sequence
   initial begin
      {rstn_i, init_done, lines_done, xfer_req, irq, marker, byte_vld, code_end} = 8'h00;
      code_byte = 8'h00;
      pix = 32'h0;
      void'($urandom(32'hCE6E8165));
      repeat (8) @(posedge clock_i);
      rstn_i <= 1'b1;
      tick(3);
      rdc(4'h0, 8'h00);
      rdc(4'h2, 8'h00);
      wr(4'h3, 8'h5A);
      rdc(4'h3, 8'h00);
      for (int k = 0; k < 12; k++) begin
         s = 8'($urandom);
         p = 8'($urandom);
         pix <= $urandom;
         s[0] = 1'b0;
         if (s[2:1] == 2'b11) s[2] = 1'b0;
         if ({p[7:6], p[4:0]} inside {[1:4]}) p[2:0] = 3'h5;
         wr(4'h0, s);
         wr(4'h1, p);
         rdc(4'h0, s);
         rdc(4'h1, p);
         chk({cbw, cbo, cbx, isel, iw, ibo, tsel, at}, {s[2:1], s[4], s[5], s[6], s[7], s[3], p[5], p[7:6], p[4:0]});
         chk(img, img_exp(s, pix));
      end
      wr(4'h2, 8'h01);
      chk(ctx_init, 1'b1);
      pulse(0);
      chk(ctx_init, 1'b0);
      rdc(4'h2, 8'h01);
      wr(4'h2, 8'h04);
      chk(ctx_ls, 1'b1);
      wr(4'h2, 8'h02);
      chk({ctx_ls, run}, 2'b01);
      rdc(4'h2, 8'h00);
      pulse(1);
      chk(run, 1'b0);
      rdc(4'h2, 8'h01);
      wr(4'h2, 8'h0A);
      pulse(1);
      chk(run, 1'b0);
      rdc(4'h2, 8'h20);
      wr(4'h2, 8'h0A);
      chk(run, 1'b1);
      wr(4'h2, 8'h08);
      tick(2);
      chk({run, n_stop[7:0]}, 9'h001);
      s = 8'($urandom);
      {xfer_req, irq} <= s[1:0];
      pulse(2);
      rdc(4'h2, {3'b001, 1'b0, s[0], 1'b1, s[1], 1'b0});
      {xfer_req, irq} <= 2'b00;
      wr(4'h0, 8'h00);
      for (int i = 0; i < 9; i++) send(8'hFF, 1'b0);
      send(8'h3C, 1'b0);
      @(posedge clock_i) byte_vld <= 1'b0;
      rdc(4'h2, 8'h34);
      for (int k = 0; k < 4; k++) begin
         wr(4'h0, {2'b00, k[1], k[0], 4'b0100});
         p = 8'($urandom);
         s = 8'($urandom);
         d = 8'($urandom);
         send(p, 1'b0);
         send(s, 1'b0);
         send(d, 1'b1);
         @(posedge clock_i) {byte_vld, code_end} <= 2'b00;
         tick(2);
         chk(last_word, code_exp({d, s, p}, k[1], k[0]));
         send(p, 1'b1);
         @(posedge clock_i) {byte_vld, code_end} <= 2'b00;
         tick(2);
         chk(last_word, code_exp({16'h0, p}, k[1], k[0]));
      end
      wr(4'h0, 8'h22);
      send(p, 1'b0);
      send(s, 1'b1);
      @(posedge clock_i) {byte_vld, code_end} <= 2'b00;
      tick(2);
      chk(last_word, {16'h0, p, s});
      wr(4'h0, 8'h01);
      tick(1);
      chk({chip_rst, ctx_init, run}, 3'b100);
      rdc(4'h0, 8'h01);
      rdc(4'h1, 8'h00);
      wr(4'h0, 8'h00);
      tick(1);
      chk(chip_rst, 1'b0);
      rdc(4'h2, 8'h00);
      test_done();
   end
endmodule : test_arith_coder_host_control_regs
